// ===== design/rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 5'h00
`define OFS_STATUS 5'h01
`define OFS_INT_ENABLES 5'h02
`define OFS_INT_FLAGS 5'h03
`define OFS_STAGING 5'h04
`define OFS_DEBUG 5'h05
`define OFS_DRIFT 5'h06
`define OFS_SOURCE 5'h07
`define OFS_COUNT_LO 5'h08
`define OFS_COUNT_HI 5'h09
`define OFS_LIMIT_LO 5'h0A
`define OFS_LIMIT_HI 5'h0B
`define OFS_MATCH_LO 5'h0C
`define OFS_MATCH_HI 5'h0D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_WRAP 0
`define BIT_MATCH 1
`define BIT_ENABLE 0
`define BIT_CORR_EN 2
`define DIV_LSB 3
`define DIV_MSB 6
`define BIT_SIGN 7
`define AMOUNT_MSB 6
`define BIT_RUN_DEBUG 0
`define BIT_COUNT_BUSY 1
`define BIT_LIMIT_BUSY 2
`define BIT_MATCH_BUSY 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_LIMIT 16'hFFFF
`define RST_MATCH 16'h0000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SYNC_CYCLES 2'h2
`define PPM_INTERVAL 20'hF4240

`endif

// ===== design/rtc_pkg.sv
package rtc_pkg;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        internal_fast_osc,
        internal_slow_osc,
        crystal_osc_source,
        external_clock_input
    } source_sel_t;

    typedef struct packed {
        logic sign;
        logic [6:0] amount;
    } drift_t;

endpackage

// ===== design/write_sync.sv
`timescale 1ns/10ps
`include "rtc_params.svh"

module write_sync (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic cycle_in,
    output logic pending_out,
    output logic load_out
);
    import rtc_pkg::*;

    logic [1:0] left;

    // ----------------------------------------------------------------
    // two counter clock cycles from write to effect
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            left <= 2'h0;
        end else if (start_in) begin
            left <= `SYNC_CYCLES;
        end else if (cycle_in && left != 2'h0) begin
            left <= left - 2'h1;
        end
    end

    assign pending_out = (left != 2'h0);
    assign load_out = cycle_in && (left == 2'h1) && !start_in;

endmodule // write_sync

// ===== design/tick_prescaler.sv
`timescale 1ns/10ps
`include "rtc_params.svh"

module tick_prescaler (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cycle_in,
    input wire logic run_in,
    input wire logic [3:0] div_in,
    input wire logic corr_en_in,
    input wire rtc_pkg::drift_t drift_in,
    output logic tick_out
);
    import rtc_pkg::*;

    logic [15:0] presc;
    logic [19:0] acc;
    logic [19:0] acc_sum;
    logic corr_due;
    logic [1:0] step;
    logic [15:0] next_presc;
    logic [15:0] old_hi;
    logic [15:0] new_hi;
    logic advance;

    // ----------------------------------------------------------------
    // drift spreading: amount corrections per million cycles
    // ----------------------------------------------------------------
    assign advance = cycle_in && run_in;
    assign acc_sum = acc + {13'h0, drift_in.amount};
    assign corr_due = corr_en_in && (acc_sum >= `PPM_INTERVAL);

    always_ff @(posedge clk_in) begin
        if (srst_in || !corr_en_in) begin
            acc <= 20'h0;
        end else if (advance) begin
            acc <= corr_due ? acc_sum - `PPM_INTERVAL : acc_sum;
        end
    end

    // ----------------------------------------------------------------
    // slower skips one step, faster takes two
    // ----------------------------------------------------------------
    assign step = !corr_due ? 2'h1 : (drift_in.sign ? 2'h2 : 2'h0);
    assign next_presc = presc + {14'h0, step};
    assign old_hi = presc >> div_in;
    assign new_hi = next_presc >> div_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            presc <= 16'h0;
            tick_out <= 1'b0;
        end else begin
            if (advance) begin
                presc <= next_presc;
            end
            tick_out <= advance && (old_hi != new_hi);
        end
    end

endmodule // tick_prescaler

// ===== design/rtc_counter_compare_regs.sv
// Function
// - match flag sets when count equals match value
// - wrap flag sets when count reaches limit and returns to zero
// - writing one clears a flag, zero leaves it; flags reset clear
// - one shared staging byte at 0x4 serves all 16-bit registers
// - run_in_debug zero stops prescaler and counting during debug halt; register writes and pending loads still take effect
// - sign zero slows the prescaler, sign one speeds it up
// - amount gives corrections per million counter clock cycles
// - two-bit source select picks one of four counter clocks
// - count is 16 bits, resets zero, low byte then high byte
// - count write takes effect two counter clock cycles later
// - wrap limit is 16 bits, two bytes, resets to all ones
// - match value is 16 bits, resets zero, high byte at plus one
// - tick divider divides counter clock by two to the field
// - count_sync_pending reads one while count write is in flight
// - enabled match or wrap flag requests an interrupt
`timescale 1ns/10ps
`include "rtc_params.svh"

module rtc_counter_compare_regs (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire rtc_pkg::bus_req_t bus_in,
    input wire logic [3:0] osc_ticks_in,
    input wire logic debug_halt_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    output logic [15:0] count_out
);
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] control;
    logic [1:0] int_enables;
    logic [1:0] int_flags;
    logic [7:0] staging;
    logic run_in_debug;
    drift_t drift;
    source_sel_t source_sel;
    logic [15:0] count;
    logic [15:0] limit;
    logic [15:0] match;
    logic [15:0] count_hold;
    logic [15:0] limit_hold;
    logic [15:0] match_hold;
    logic irq;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire wr = bus_in.wr;
    wire rd = bus_in.rd;
    wire [7:0] wdata = bus_in.wdata;
    wire wr_control = wr && bus_in.addr == `OFS_CONTROL;
    wire wr_enables = wr && bus_in.addr == `OFS_INT_ENABLES;
    wire wr_flags = wr && bus_in.addr == `OFS_INT_FLAGS;
    wire wr_staging = wr && bus_in.addr == `OFS_STAGING;
    wire wr_debug = wr && bus_in.addr == `OFS_DEBUG;
    wire wr_drift = wr && bus_in.addr == `OFS_DRIFT;
    wire wr_source = wr && bus_in.addr == `OFS_SOURCE;
    wire wr_lo_any = wr && (bus_in.addr == `OFS_COUNT_LO
        || bus_in.addr == `OFS_LIMIT_LO || bus_in.addr == `OFS_MATCH_LO);
    wire wr_count_hi = wr && bus_in.addr == `OFS_COUNT_HI;
    wire wr_limit_hi = wr && bus_in.addr == `OFS_LIMIT_HI;
    wire wr_match_hi = wr && bus_in.addr == `OFS_MATCH_HI;
    wire rd_count_lo = rd && bus_in.addr == `OFS_COUNT_LO;
    wire rd_limit_lo = rd && bus_in.addr == `OFS_LIMIT_LO;
    wire rd_match_lo = rd && bus_in.addr == `OFS_MATCH_LO;
    wire [15:0] wr_word = {wdata, staging};

    // ----------------------------------------------------------------
    // counter clock selection and run gating
    // ----------------------------------------------------------------
    wire cycle = osc_ticks_in[source_sel];
    wire enabled = control[`BIT_ENABLE];
    wire halted = debug_halt_in && !run_in_debug;
    wire run = enabled && !halted;
    wire corr_en = control[`BIT_CORR_EN];
    wire [3:0] div_sel = control[`DIV_MSB:`DIV_LSB];
    wire tick;

    tick_prescaler tick_prescaler_inst (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .cycle_in(cycle),
        .run_in(run),
        .div_in(div_sel),
        .corr_en_in(corr_en),
        .drift_in(drift),
        .tick_out(tick)
    );

    // ----------------------------------------------------------------
    // write crossings into the counter clock domain
    // ----------------------------------------------------------------
    wire count_sync_pending;
    wire limit_sync_pending;
    wire match_sync_pending;
    wire count_load;
    wire limit_load;
    wire match_load;

    write_sync u_count_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(wr_count_hi),
        .cycle_in(cycle),
        .pending_out(count_sync_pending),
        .load_out(count_load)
    );

    write_sync u_limit_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(wr_limit_hi),
        .cycle_in(cycle),
        .pending_out(limit_sync_pending),
        .load_out(limit_load)
    );

    write_sync u_match_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(wr_match_hi),
        .cycle_in(cycle),
        .pending_out(match_sync_pending),
        .load_out(match_load)
    );

    // ----------------------------------------------------------------
    // counting and events
    // ----------------------------------------------------------------
    wire at_limit = (count == limit);
    wire step = tick && run && !count_load;
    wire [15:0] count_inc = count + 16'h0001;
    wire [15:0] count_stepped = at_limit ? 16'h0000 : count_inc;
    wire [15:0] next_count = count_load ? count_hold :
        (step ? count_stepped : count);
    wire wrap_event = step && at_limit;
    wire match_event = (step || count_load) && (next_count == match);
    wire [1:0] events = {match_event, wrap_event};
    wire [1:0] clear_bits = wr_flags ? wdata[1:0] : 2'b00;
    wire [1:0] next_flags = (int_flags & ~clear_bits) | events;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            control <= `RST_BYTE;
            int_enables <= 2'b00;
            run_in_debug <= 1'b0;
            drift <= drift_t'(`RST_BYTE);
            source_sel <= internal_fast_osc;
        end else begin
            if (wr_control) begin
                control <= {1'b0, wdata[6:2], 1'b0, wdata[0]};
            end
            if (wr_enables) begin
                int_enables <= wdata[1:0];
            end
            if (wr_debug) begin
                run_in_debug <= wdata[`BIT_RUN_DEBUG];
            end
            if (wr_drift) begin
                drift <= drift_t'(wdata);
            end
            if (wr_source) begin
                source_sel <= source_sel_t'(wdata[1:0]);
            end
        end
    end

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            int_flags <= 2'b00;
        end else begin
            int_flags <= next_flags;
        end
    end

    // ----------------------------------------------------------------
    // staging byte
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            staging <= `RST_BYTE;
        end else if (wr_staging || wr_lo_any) begin
            staging <= wdata;
        end else if (rd_count_lo) begin
            staging <= count[15:8];
        end else if (rd_limit_lo) begin
            staging <= limit[15:8];
        end else if (rd_match_lo) begin
            staging <= match[15:8];
        end
    end

    // ----------------------------------------------------------------
    // 16-bit registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_hold <= `RST_COUNT;
            limit_hold <= `RST_LIMIT;
            match_hold <= `RST_MATCH;
        end else begin
            if (wr_count_hi) begin
                count_hold <= wr_word;
            end
            if (wr_limit_hi) begin
                limit_hold <= wr_word;
            end
            if (wr_match_hi) begin
                match_hold <= wr_word;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count <= `RST_COUNT;
            limit <= `RST_LIMIT;
            match <= `RST_MATCH;
        end else begin
            count <= next_count;
            if (limit_load) begin
                limit <= limit_hold;
            end
            if (match_load) begin
                match <= match_hold;
            end
        end
    end

    // ----------------------------------------------------------------
    // sync status
    // ----------------------------------------------------------------
    wire [7:0] status_byte = {4'h0, match_sync_pending, limit_sync_pending,
        count_sync_pending, 1'b0};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (bus_in.addr)
            `OFS_CONTROL: rd_mux = control;
            `OFS_STATUS: rd_mux = status_byte;
            `OFS_INT_ENABLES: rd_mux = {6'h00, int_enables};
            `OFS_INT_FLAGS: rd_mux = {6'h00, int_flags};
            `OFS_STAGING: rd_mux = staging;
            `OFS_DEBUG: rd_mux = {7'h00, run_in_debug};
            `OFS_DRIFT: rd_mux = drift;
            `OFS_SOURCE: rd_mux = {6'h00, source_sel};
            `OFS_COUNT_LO: rd_mux = count[7:0];
            `OFS_LIMIT_LO: rd_mux = limit[7:0];
            `OFS_MATCH_LO: rd_mux = match[7:0];
            `OFS_COUNT_HI: rd_mux = staging;
            `OFS_LIMIT_HI: rd_mux = staging;
            `OFS_MATCH_HI: rd_mux = staging;
            default: rd_mux = 8'h00;
        endcase
    end

    wire [7:0] next_rdata = rd ? rd_mux : 8'h00;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    wire next_irq = |(next_flags & int_enables);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign irq_out = irq;
    assign count_out = count;

endmodule // rtc_counter_compare_regs

// ===== bench/rtc_regs_monitor.sv
`timescale 1ns/10ps
module rtc_regs_monitor (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire rtc_pkg::bus_req_t bus_in,
    input wire logic [3:0] osc_ticks_in,
    input wire logic debug_halt_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out,
    input wire logic [15:0] count_out
);
    import rtc_pkg::*;
    // ------------------------------------------------
    // shadow of the interrupt enables
    // ------------------------------------------------
    logic [1:0] en;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            en <= 2'h0;
        end else if (bus_in.wr && bus_in.addr == 5'h02) begin
            en <= bus_in.wdata[1:0];
        end
    end
    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_rdata_idle: assert property (
        !$past(bus_in.rd) |-> rdata_out == 8'h00) else $error("data idle");
    a_unmapped_zero: assert property (
        bus_in.rd && bus_in.addr > 5'h0D |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_flag_bits: assert property (
        bus_in.rd && bus_in.addr == 5'h03 |=> rdata_out[7:2] == 6'h00)
        else $error("flag spare bits set");
    a_debug_bits: assert property (
        bus_in.rd && bus_in.addr == 5'h05 |=> rdata_out[7:1] == 7'h00)
        else $error("debug spare bits set");
    a_source_bits: assert property (
        bus_in.rd && bus_in.addr == 5'h07 |=> rdata_out[7:2] == 6'h00)
        else $error("source spare bits set");
    a_staging_echo: assert property (
        bus_in.wr && bus_in.addr == 5'h04 ##1 bus_in.rd &&
        bus_in.addr inside {5'h09, 5'h0B, 5'h0D}
        |=> rdata_out == $past(bus_in.wdata, 2)) else $error("high read");
    a_low_staging: assert property (
        bus_in.wr && bus_in.addr inside {5'h08, 5'h0A, 5'h0C} ##1
        bus_in.rd && bus_in.addr == 5'h04
        |=> rdata_out == $past(bus_in.wdata, 2)) else $error("low write");
    a_count_still: assert property (
        (osc_ticks_in == 4'h0) [*3] |=> $stable(count_out))
        else $error("count moved without source pulses");
    a_irq_masked: assert property (
        en == 2'h0 |=> !irq_out) else $error("irq with enables clear");
endmodule // rtc_regs_monitor

bind rtc_counter_compare_regs rtc_regs_monitor rtc_regs_monitor_inst (
    .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in),
    .osc_ticks_in(osc_ticks_in), .debug_halt_in(debug_halt_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .count_out(count_out)
);

// ===== bench/rtc_counter_compare_regs_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[ERR] %0t got %h expected %h", $time, g, e); \
    end \
end

module rtc_counter_compare_regs_tb_top;
    import rtc_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    bus_req_t bus_in = '0;
    logic [3:0] osc_ticks_in = 4'h0;
    logic debug_halt_in = 1'b0;
    logic [7:0] rdata_out;
    logic irq_out;
    logic [15:0] count_out;
    int fail_count = 0;
    int checks = 0;
    int d;
    logic [7:0] exp_q[$];
    logic [7:0] ev;
    logic [7:0] r;
    logic [31:0] seed = 32'h0000C3A2;
    logic pend = 1'b0;

    rtc_counter_compare_regs rtc_counter_compare_regs_inst (
        .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus_in),
        .osc_ticks_in(osc_ticks_in), .debug_halt_in(debug_halt_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .count_out(count_out)
    );

    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic acc(input logic [4:0] a, input logic [7:0] dt,
                       input logic w, input logic rq);
        bus_in <= '{addr: a, wdata: dt, wr: w, rd: rq};
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] dt);
        acc(a, dt, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic pulse(input logic [3:0] m, input int n);
        bus_in <= '0;
        repeat (n) begin
            osc_ticks_in <= m;
            @(posedge clk_in);
            osc_ticks_in <= 4'h0;
            @(posedge clk_in);
        end
        repeat (2) @(posedge clk_in);
    endtask
    task automatic do_reset();
        srst_in <= 1'b1;
        bus_in <= '0;
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // read data watcher
    always @(posedge clk_in) begin
        if (pend) begin
            ev = exp_q.pop_front();
            `CHK(rdata_out, ev)
        end
        pend = bus_in.rd;
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        do_reset();
        for (d = 3; d < 14; d++) begin
            rd(d[4:0], (d == 10 || d == 11) ? 8'hFF : 8'h00);
        end
        wr(5'h1E, 8'hFF);
        rd(5'h1E, 8'h00);
        for (d = 0; d < 4; d++) begin
            r = rnd();
            wr(5'h04, r);
            rd(5'h0D, r);
            wr(5'h0C, ~r);
            rd(5'h04, ~r);
            wr(5'h05, r);
            rd(5'h05, r & 8'h01);
            wr(5'h06, r);
            rd(5'h06, r);
            wr(5'h07, 8'hFC | d[7:0]);
            rd(5'h07, d[7:0]);
        end
        rd(5'h01, 8'h00);
        wr(5'h08, 8'h34);
        wr(5'h09, 8'h12);
        rd(5'h01, 8'h02);
        pulse(4'h7, 3);
        `CHK(count_out, 16'h0000)
        pulse(4'h8, 1);
        `CHK(count_out, 16'h0000)
        pulse(4'h8, 1);
        `CHK(count_out, 16'h1234)
        rd(5'h01, 8'h00);
        rd(5'h08, 8'h34);
        rd(5'h09, 8'h12);
        for (d = 0; d < 4; d++) begin
            do_reset();
            wr(5'h07, {6'h00, d[1:0]});
            wr(5'h00, {1'b0, d[3:0], 3'b001});
            pulse(4'h1 << d, 3 << d);
            `CHK(count_out, 16'h0003)
        end
        do_reset();
        wr(5'h0A, 8'h05);
        wr(5'h0B, 8'h00);
        rd(5'h01, 8'h04);
        wr(5'h0C, 8'h03);
        wr(5'h0D, 8'h00);
        rd(5'h01, 8'h0C);
        pulse(4'h1, 3);
        rd(5'h01, 8'h00);
        wr(5'h00, 8'h01);
        pulse(4'h1, 3);
        `CHK(count_out, 16'h0003)
        rd(5'h03, 8'h02);
        pulse(4'h1, 3);
        `CHK(count_out, 16'h0000)
        rd(5'h03, 8'h03);
        wr(5'h03, 8'h00);
        rd(5'h03, 8'h03);
        wr(5'h02, 8'h03);
        pulse(4'h0, 0);
        `CHK(irq_out, 1'b1)
        wr(5'h03, 8'h01);
        rd(5'h03, 8'h02);
        wr(5'h03, 8'h02);
        rd(5'h03, 8'h00);
        pulse(4'h0, 0);
        `CHK(irq_out, 1'b0)
        debug_halt_in <= 1'b1;
        wr(5'h05, 8'h00);
        pulse(4'h1, 4);
        `CHK(count_out, 16'h0000)
        wr(5'h05, 8'h01);
        pulse(4'h1, 4);
        `CHK(count_out, 16'h0004)
        debug_halt_in <= 1'b0;
        do_reset();
        wr(5'h06, 8'hFF);
        wr(5'h00, 8'h0D);
        pulse(4'h1, 7875);
        `CHK(count_out, 16'h0F62)
        do_reset();
        wr(5'h06, 8'h7F);
        wr(5'h00, 8'h05);
        pulse(4'h1, 7875);
        `CHK(count_out, 16'h1EC2)
        if (exp_q.size() != 0) begin
            fail_count++;
        end
        stop_test();
    end
endmodule // rtc_counter_compare_regs_tb_top
